// ### bench/pmc_ctrl_checker.sv
// Port-level assertions of the mode and reset controller.
`include "pmc_defines.svh"
`timescale 1ns/1ns
module pmc_ctrl_checker (
	input wire logic                  i_clk,
	input wire logic                  i_srst,
	input wire logic                  i_reset_n_pin,
	input wire logic                  i_addr_trap,
	input wire logic                  i_wdt_reset,
	input wire logic                  i_wdt_irq,
	input wire logic [3:0]            i_addr,
	input wire logic [7:0]            i_wdata,
	input wire logic                  i_wr,
	input wire pmc_pkg::pmc_mode_type o_mode,
	input wire logic                  o_core_reset,
	input wire logic                  o_reset_pin_oe_n,
	input wire logic                  o_reset_pin_out,
	input wire logic                  o_sys_clk_low,
	input wire logic                  o_resume_next,
	input wire logic                  o_tb_isr_req,
	input wire logic                  o_wdt_isr_req,
	input wire logic [15:0]           o_start_vector,
	input wire logic [7:0]            o_prescaler
);
	import pmc_pkg::*;
	localparam int RMAX = `PMC_RST_CYC + 4;
	logic       sw;
	logic       run;
	logic [6:0] rlen_r;
	assign sw  = i_wr && i_addr == 4'h0 && !o_core_reset;
	assign run = o_mode inside {PMC_HIGH_FIRST, PMC_DUAL_RUN};
	// Only counted with the pin high, since a pin held low may keep reset for any time.
	always_ff @(posedge i_clk) begin
		rlen_r <= (o_core_reset && i_reset_n_pin && !i_srst) ? rlen_r + 7'h01 : 7'h00;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	a_pin_not_driven: assert property (o_reset_pin_oe_n && o_reset_pin_out)
		else $error("reset pin driven");
	a_vector_fixed: assert property (o_start_vector == 16'hfffe)
		else $error("start vector wrong");
	a_reset_len_bound: assert property (rlen_r <= RMAX)
		else $error("internal reset too long");
	a_int_reset_source: assert property ((i_addr_trap || i_wdt_reset) && !o_core_reset |->
		##[1:3] o_core_reset) else $error("internal reset missing");
	a_pin_reset_now: assert property ($fell(i_reset_n_pin) |-> ##[1:4] o_core_reset)
		else $error("pin reset missing");
	a_halt_enters_idle: assert property (sw && run && i_wdata[7] && !i_wdata[5] && i_wdata[2]
		&& !i_wdt_irq |=> o_mode == PMC_DEEP_IDLE) else $error("idle not entered");
	a_wdt_blocks_idle: assert property (sw && run && i_wdata[7] && !i_wdata[5] && i_wdata[2]
		&& i_wdt_irq |=> o_wdt_isr_req && o_mode == $past(o_mode)) else $error("wdt");
	a_low_clock_sel: assert property (sw && run && i_wdata[7:5] == 3'b111 && !i_wdata[2]
		|=> o_sys_clk_low && o_mode == PMC_LOW_RUN) else $error("low switch");
	a_sync_before_high: assert property (sw && o_mode == PMC_LOW_RUN && i_wdata[7:5] == 3'b110
		&& !i_wdata[2] |=> (o_sys_clk_low && o_mode == PMC_SYNC_HIGH)[*3]
		##1 (o_mode == PMC_DUAL_RUN && !o_sys_clk_low)) else $error("sync wrong");
	a_sysclk_fail_rst: assert property (sw && run && !i_wdata[7] && !i_wdata[5]
		|=> ##[0:2] o_core_reset) else $error("sysclk reset missing");
	a_prescaler_clear: assert property ($fell(i_srst) |-> o_prescaler == 8'h00)
		else $error("prescaler not cleared");
	a_wake_exclusive: assert property (o_tb_isr_req |-> !o_resume_next ##1 !o_tb_isr_req)
		else $error("wake pulses wrong");
	c_isr: cover property (o_tb_isr_req);
	c_resume: cover property (o_resume_next);
	c_wdt: cover property (o_wdt_isr_req);
	c_sync: cover property (o_mode == PMC_SYNC_HIGH);
endmodule : pmc_ctrl_checker

// ### bench/tb.sv
// Self-checking bench of the mode and reset controller.
`include "pmc_defines.svh"
`timescale 1ns/1ns
module tb;
	import pmc_pkg::*;
	localparam int RMAX = `PMC_RST_CYC + 2;
	logic i_clk, i_srst, i_ce, i_reset_n_pin, i_tb_clk, i_addr_trap, i_wdt_reset, i_wdt_irq;
	logic i_wr, i_rd, o_core_reset, o_reset_pin_oe_n, o_reset_pin_out, o_sys_clk_low;
	logic o_hi_osc_en, o_lo_osc_en, o_cpu_halt, o_resume_next, o_tb_isr_req, o_wdt_isr_req;
	logic seen_isr, seen_res, seen_wdt;
	logic [3:0]   i_addr;
	logic [7:0]   i_wdata, o_rdata, o_prescaler, d;
	logic [15:0]  o_start_vector;
	pmc_mode_type o_mode;
	int           n_fail, checked, n;
	pmc_ctrl dut (.*);
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (o_tb_isr_req) seen_isr <= 1'b1;
		if (o_resume_next) seen_res <= 1'b1;
		if (o_wdt_isr_req) seen_wdt <= 1'b1;
	end
	task automatic results();
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		i_addr  <= a;
		i_wdata <= v;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		cyc(1);
	endtask : wr
	task automatic rdchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, string s);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(s, {8'h00, e}, {8'h00, o_rdata & m});
		cyc(1);
	endtask : rdchk
	// A wake with service needs all three enables and the level-8 selector at zero.
	function automatic logic isr_exp(input logic [2:0] ie, input logic tb);
		return ie[0] & ie[1] & tb & !ie[2];
	endfunction : isr_exp
	task automatic idle_run(input logic [2:0] ie, input logic tb, input logic [7:0] sc,
		input pmc_mode_type back);
		wr(`PMC_OFF_INTCTL, {5'h00, ie});
		wr(`PMC_OFF_TBCTL, {tb, 7'h00});
		seen_isr <= 1'b0;
		seen_res <= 1'b0;
		wr(`PMC_OFF_SYSCTL, sc | 8'h04);
		chk("idle", 16'h1, {15'h0, o_cpu_halt});
		chk("idle mode", 16'(PMC_DEEP_IDLE), 16'(o_mode));
		i_tb_clk <= 1'b1;
		cyc(4);
		i_tb_clk <= 1'b0;
		cyc(8);
		chk("isr", {15'h0, isr_exp(ie, tb)}, {15'h0, seen_isr});
		chk("resume", {15'h0, !isr_exp(ie, tb)}, {15'h0, seen_res});
		chk("back", 16'(back), 16'(o_mode));
		rdchk(`PMC_OFF_SYSCTL, 8'hff, sc, "halt clear");
		rdchk(`PMC_OFF_INTCTL, 8'h08, {4'h0, tb, 3'h0}, "latch");
	endtask : idle_run
	task automatic after_rst(input logic [7:0] cause);
		cyc(2);
		n = 0;
		while (o_core_reset === 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		chk("reset len", 16'h1, {15'h0, n > 0 && n <= RMAX});
		chk("post mode", 16'(PMC_HIGH_FIRST), 16'(o_mode));
		rdchk(`PMC_OFF_STATUS, cause, cause, "cause");
		rdchk(`PMC_OFF_INTCTL, 8'hff, 8'h00, "int clear");
	endtask : after_rst
	task automatic int_rst(input int src, input logic [7:0] cause);
		if (src == 0) i_addr_trap <= 1'b1;
		else if (src == 1) i_wdt_reset <= 1'b1;
		else i_reset_n_pin <= 1'b0;
		cyc(src == 2 ? 4 : 1);
		i_addr_trap   <= 1'b0;
		i_wdt_reset   <= 1'b0;
		i_reset_n_pin <= 1'b1;
		after_rst(cause);
	endtask : int_rst
	initial begin
		#(40 * 20000);
		n_fail++;
		results();
	end
	initial begin
		{i_srst, i_ce, i_reset_n_pin} = 3'b111;
		{i_tb_clk, i_addr_trap, i_wdt_reset, i_wdt_irq, i_wr, i_rd} = 6'h00;
		{i_addr, i_wdata, seen_isr, seen_res, seen_wdt} = 15'h0;
		n_fail  = 0;
		checked = 0;
		void'($urandom(63878));
		cyc(6);
		i_srst <= 1'b0;
		after_rst(8'h01);
		chk("vector", 16'hfffe, o_start_vector);
		chk("pin", 16'h3, {14'h0, o_reset_pin_oe_n, o_reset_pin_out});
		rdchk(`PMC_OFF_SYSCTL, 8'hff, 8'hc0, "sysctl");
		for (int a = 4; a < 16; a++) rdchk(4'(a), 8'hff, 8'h00, "unmapped");
		repeat (6) begin
			d = 8'($urandom);
			wr(`PMC_OFF_INTCTL, {5'h00, d[2:0]});
			rdchk(`PMC_OFF_INTCTL, 8'h07, {5'h00, d[2:0]}, "intctl");
			wr(`PMC_OFF_TBCTL, d & 8'h80);
			rdchk(`PMC_OFF_TBCTL, 8'h80, d & 8'h80, "tbctl");
			idle_run(d[2:0], d[7], 8'hc0, PMC_DUAL_RUN);
		end
		idle_run(3'b011, 1'b1, 8'hc0, PMC_DUAL_RUN);
		idle_run(3'b111, 1'b1, 8'hc0, PMC_DUAL_RUN);
		i_wdt_irq <= 1'b1;
		seen_wdt  <= 1'b0;
		wr(`PMC_OFF_SYSCTL, 8'hc4);
		i_wdt_irq <= 1'b0;
		chk("wdt isr", 16'h1, {15'h0, seen_wdt});
		chk("no idle", 16'(PMC_DUAL_RUN), 16'(o_mode));
		wr(`PMC_OFF_SYSCTL, 8'he0);
		chk("low", 16'h1, {15'h0, o_sys_clk_low});
		wr(`PMC_OFF_SYSCTL, 8'h60);
		chk("hi stop", 16'h0, {15'h0, o_hi_osc_en});
		chk("low run", 16'(PMC_LOW_RUN), 16'(o_mode));
		idle_run(3'b011, 1'b1, 8'h60, PMC_LOW_RUN);
		wr(`PMC_OFF_SYSCTL, 8'he0);
		cyc(4);
		wr(`PMC_OFF_SYSCTL, 8'hc0);
		chk("sync", 16'(PMC_SYNC_HIGH), 16'(o_mode));
		cyc(3);
		chk("dual", 16'(PMC_DUAL_RUN), 16'(o_mode));
		wr(`PMC_OFF_SYSCTL, 8'h40);
		after_rst(8'h08);
		wr(`PMC_OFF_SYSCTL, 8'he0);
		int_rst(2, 8'h01);
		int_rst(0, 8'h02);
		int_rst(1, 8'h04);
		results();
	end
endmodule : tb
bind pmc_ctrl pmc_ctrl_checker chk (.*);

// ### rtl/pmc_ctrl.sv
// Operating-mode, system-clock and reset controller of the microcontroller core.
//
// What this block does
// - All three enables set: leave deep idle on time-base falling edge, then service interrupt.
// - Exit uses the asynchronous time-base clock, so idle may be shorter than a period.
// - Watchdog interrupt just before entry: service it and do not enter idle.
// - Level-8 source select set: resume at next instruction, no interrupt service.
// - Clock-select 1 picks low clock; high enable 0 stops high oscillator.
// - External reset low in low run resets at once; afterwards first high run.
// - After select cleared, keep low clock until clocks are synchronised, then switch.
// - Four reset sources: pin, address trap, watchdog, system clock; three internal.
// - An internal reset request holds reset at most 24 basic-clock periods.
// - Internal reset never drives the external reset pin low.
// - Internal reset generators uninitialised at power-up; still bounded to 24 periods.
// - Reset clears master enable, individual enables and interrupt latches.
// - Reset leaves stack pointer, general registers, flags and RAM uninitialised.
// - Reset clears the timing-generator prescaler and divider.
// - Halt bit set enters deep idle; exit clears it and restores previous mode.
// - After reset, execution starts at the vector held at the top two bytes.
// - Disabling the oscillator supplying the system clock raises a system-clock reset.
//
// Local design decisions: the placing of the registers and the strobed register port.
`include "pmc_defines.svh"
`timescale 1ns/1ns
module pmc_ctrl (
	input  wire logic                     i_clk,
	input  wire logic                     i_srst,
	input  wire logic                     i_ce,
	input  wire logic                     i_reset_n_pin,
	input  wire logic                     i_tb_clk,
	input  wire logic                     i_addr_trap,
	input  wire logic                     i_wdt_reset,
	input  wire logic                     i_wdt_irq,
	input  wire logic [`PMC_ADDR_W-1:0]   i_addr,
	input  wire logic [7:0]               i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [7:0]               o_rdata,
	output pmc_pkg::pmc_mode_type         o_mode,
	output logic                          o_core_reset,
	output logic                          o_reset_pin_oe_n,
	output logic                          o_reset_pin_out,
	output logic                          o_sys_clk_low,
	output logic                          o_hi_osc_en,
	output logic                          o_lo_osc_en,
	output logic                          o_cpu_halt,
	output logic                          o_resume_next,
	output logic                          o_tb_isr_req,
	output logic                          o_wdt_isr_req,
	output logic      [15:0]              o_start_vector,
	output logic      [7:0]               o_prescaler
);
	import pmc_pkg::*;

	// The counter is six bits wide so that 37 cycles fit without wrapping.
	localparam logic [5:0] RST_CYC  = 6'(`PMC_RST_CYC < 1 ? 1 : `PMC_RST_CYC);
	localparam logic [1:0] SYNC_CYC = 2'(`PMC_SYNC_CYC);

	pmc_state_type st_r;
	pmc_state_type st_nxt;

	logic tb_fall;
	logic sys_clk_fail;
	logic wr_sys;
	logic wr_int;

	always_comb begin
		st_nxt = st_r;
		st_nxt.resume_pulse = 1'b0;
		st_nxt.isr_pulse    = 1'b0;
		st_nxt.wdt_pulse    = 1'b0;
		st_nxt.rdata        = 8'h00;
		// The pin and the time-base clock come from outside; the pin is read at its second stage, the time-base clock at its second and third.
		st_nxt.tb_s1  = i_tb_clk;
		st_nxt.tb_s2  = st_r.tb_s1;
		st_nxt.tb_s3  = st_r.tb_s2;
		st_nxt.rst_s1 = i_reset_n_pin;
		st_nxt.rst_s2 = st_r.rst_s1;
		tb_fall = st_r.tb_s3 & ~st_r.tb_s2;
		wr_sys  = i_wr && (i_addr == `PMC_OFF_SYSCTL);
		wr_int  = i_wr && (i_addr == `PMC_OFF_INTCTL);
		sys_clk_fail = 1'b0;
		if (wr_sys) begin
			sys_clk_fail = (!i_wdata[`PMC_BIT_HIEN] && !i_wdata[`PMC_BIT_LOEN])
				|| (!i_wdata[`PMC_BIT_HIEN] && !i_wdata[`PMC_BIT_CLKSEL]
					&& !st_r.sysctl[`PMC_BIT_CLKSEL])
				|| (!i_wdata[`PMC_BIT_LOEN] && st_r.sysctl[`PMC_BIT_CLKSEL]);
		end
		st_nxt.prescaler = st_r.prescaler + 8'h01;
		if (st_r.mode != PMC_DEEP_IDLE && st_r.mode != PMC_RESET) begin
			if (i_wr && i_addr == `PMC_OFF_TBCTL) begin
				st_nxt.tbctl = i_wdata;
			end
			if (wr_int) begin
				st_nxt.mie   = i_wdata[`PMC_BIT_MIE];
				st_nxt.l8en  = i_wdata[`PMC_BIT_L8EN];
				st_nxt.l8sel = i_wdata[`PMC_BIT_L8SEL];
				if (!i_wdata[`PMC_BIT_TBLATCH]) begin
					st_nxt.tb_latch = 1'b0;
				end
			end
			if (wr_sys && !sys_clk_fail) begin
				st_nxt.sysctl = i_wdata;
			end
		end
		if (i_rd) begin
			unique case (i_addr)
				`PMC_OFF_SYSCTL: st_nxt.rdata = st_r.sysctl;
				`PMC_OFF_TBCTL:  st_nxt.rdata = st_r.tbctl;
				`PMC_OFF_INTCTL: st_nxt.rdata = {4'h0, st_r.tb_latch, st_r.l8sel,
					st_r.l8en, st_r.mie};
				`PMC_OFF_STATUS: st_nxt.rdata = {1'b0, st_r.mode, st_r.rst_cause};
				default:         st_nxt.rdata = 8'h00;
			endcase
		end
		if (st_r.rst_cnt != 6'h00) begin
			st_nxt.rst_cnt = st_r.rst_cnt - 6'h01;
		end
		unique case (st_r.mode)
			PMC_RESET: begin
				if (st_r.rst_cnt <= 6'h01 && st_r.rst_s2) begin
					st_nxt.mode    = PMC_HIGH_FIRST;
					st_nxt.rst_cnt = 6'h00;
				end
			end
			PMC_HIGH_FIRST, PMC_DUAL_RUN: begin
				if (wr_sys && !sys_clk_fail && i_wdata[`PMC_BIT_CLKSEL]) begin
					st_nxt.mode = PMC_LOW_RUN;
				end else if (wr_sys && !sys_clk_fail && i_wdata[`PMC_BIT_LOEN]) begin
					st_nxt.mode = PMC_DUAL_RUN;
				end
			end
			PMC_LOW_RUN: begin
				if (wr_sys && !sys_clk_fail && !i_wdata[`PMC_BIT_CLKSEL]) begin
					// Keep running on the low clock while the clocks line up.
					st_nxt.mode     = PMC_SYNC_HIGH;
					st_nxt.sync_cnt = SYNC_CYC;
				end
			end
			PMC_SYNC_HIGH: begin
				st_nxt.sync_cnt = st_r.sync_cnt - 2'h1;
				if (st_r.sync_cnt == 2'h1) begin
					st_nxt.mode = PMC_DUAL_RUN;
				end
			end
			PMC_DEEP_IDLE: begin
				if (tb_fall) begin
					// Exit is taken regardless of the time-base enable.
					st_nxt.mode = st_r.ret_mode;
					st_nxt.sysctl[`PMC_BIT_HALT] = 1'b0;
					if (st_r.tbctl[`PMC_BIT_TBEN]) begin
						st_nxt.tb_latch = 1'b1;
					end
					if (st_r.mie && st_r.l8en && st_r.tbctl[`PMC_BIT_TBEN]
						&& !st_r.l8sel) begin
						st_nxt.isr_pulse = 1'b1;
					end else begin
						st_nxt.resume_pulse = 1'b1;
					end
				end
			end
			default: st_nxt.mode = PMC_RESET;
		endcase
		if (st_r.mode != PMC_DEEP_IDLE && st_r.mode != PMC_RESET && wr_sys
			&& !sys_clk_fail && i_wdata[`PMC_BIT_HALT]) begin
			if (i_wdt_irq) begin
				// A watchdog interrupt wins over the idle request.
				st_nxt.sysctl[`PMC_BIT_HALT] = 1'b0;
				st_nxt.wdt_pulse = 1'b1;
				st_nxt.mode      = st_r.mode;
			end else begin
				st_nxt.ret_mode = (st_nxt.mode == PMC_SYNC_HIGH) ? PMC_LOW_RUN : st_nxt.mode;
				st_nxt.mode     = PMC_DEEP_IDLE;
			end
		end
		// Internal resets restart the bounded counter; the pin is never driven.
		if (i_addr_trap || i_wdt_reset || sys_clk_fail) begin
			st_nxt = pmc_reset_state(st_nxt, RST_CYC);
			st_nxt.rst_cause = {sys_clk_fail, i_wdt_reset, i_addr_trap, 1'b0};
		end
		if (!st_r.rst_s2) begin
			st_nxt = pmc_reset_state(st_nxt, 6'h00);
			st_nxt.rst_cause = 4'h1;
		end
	end

	// Only control state is cleared; CPU registers and RAM live elsewhere untouched.
	function automatic pmc_state_type pmc_reset_state(input pmc_state_type s,
		input logic [5:0] cnt);
		pmc_state_type r;
		r           = s;
		r.mode      = PMC_RESET;
		r.ret_mode  = PMC_HIGH_FIRST;
		r.sysctl    = `PMC_SYSCTL_RST;
		r.tbctl     = 8'h00;
		r.mie       = 1'b0;
		r.l8en      = 1'b0;
		r.l8sel     = 1'b0;
		r.tb_latch  = 1'b0;
		r.rst_cnt   = cnt;
		r.sync_cnt  = 2'h0;
		r.prescaler = 8'h00;
		return r;
	endfunction : pmc_reset_state

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_r           <= '0;
			st_r.mode      <= PMC_RESET;
			st_r.ret_mode  <= PMC_HIGH_FIRST;
			st_r.sysctl    <= `PMC_SYSCTL_RST;
			st_r.rst_s1    <= 1'b1;
			st_r.rst_s2    <= 1'b1;
			st_r.rst_cnt   <= RST_CYC;
			st_r.rst_cause <= 4'h1;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_rdata          = st_r.rdata;
	assign o_mode           = st_r.mode;
	assign o_core_reset     = (st_r.mode == PMC_RESET);
	assign o_reset_pin_out  = 1'b1;
	assign o_reset_pin_oe_n = 1'b1;
	assign o_sys_clk_low    = (st_r.mode == PMC_LOW_RUN) || (st_r.mode == PMC_SYNC_HIGH)
		|| (st_r.mode == PMC_DEEP_IDLE && st_r.ret_mode == PMC_LOW_RUN);
	assign o_hi_osc_en      = st_r.sysctl[`PMC_BIT_HIEN];
	assign o_lo_osc_en      = st_r.sysctl[`PMC_BIT_LOEN];
	assign o_cpu_halt       = (st_r.mode == PMC_DEEP_IDLE);
	assign o_resume_next    = st_r.resume_pulse;
	assign o_tb_isr_req     = st_r.isr_pulse;
	assign o_wdt_isr_req    = st_r.wdt_pulse;
	assign o_start_vector   = `PMC_RESET_VECTOR;
	assign o_prescaler      = st_r.prescaler;
endmodule : pmc_ctrl

// ### rtl/pmc_defines.svh
// Offsets, field positions, reset values and timing counts of the mode and reset controller.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

`define PMC_ADDR_W         4
`define PMC_OFF_SYSCTL     4'h0
`define PMC_OFF_TBCTL      4'h1
`define PMC_OFF_INTCTL     4'h2
`define PMC_OFF_STATUS     4'h3
`define PMC_OFF_VECTOR     4'h4
`define PMC_BIT_HALT       2
`define PMC_BIT_CLKSEL     5
`define PMC_BIT_LOEN       6
`define PMC_BIT_HIEN       7
`define PMC_SYSCTL_RST     8'hc0
`define PMC_BIT_TBEN       7
`define PMC_BIT_MIE        0
`define PMC_BIT_L8EN       1
`define PMC_BIT_L8SEL      2
`define PMC_BIT_TBLATCH    3
`define PMC_RESET_VECTOR   16'hfffe
`define PMC_CLK_MHZ        25
`define PMC_RST_BASIC_CYC  24
`define PMC_BASIC_MHZ      16
// Internal reset length: 24 basic-clock periods rounded down to our clock, at least one cycle.
`define PMC_RST_CYC        ((`PMC_RST_BASIC_CYC * `PMC_CLK_MHZ) / `PMC_BASIC_MHZ)
`define PMC_SYNC_CYC       3

`endif

// ### rtl/pmc_pkg.sv
// Types of the mode and reset controller.
package pmc_pkg;
	typedef enum logic [2:0] {
		PMC_RESET,
		PMC_HIGH_FIRST,
		PMC_DUAL_RUN,
		PMC_LOW_RUN,
		PMC_DEEP_IDLE,
		PMC_SYNC_HIGH
	} pmc_mode_type;

	typedef struct packed {
		pmc_mode_type mode;
		pmc_mode_type ret_mode;
		logic [7:0]   sysctl;
		logic [7:0]   tbctl;
		logic         mie;
		logic         l8en;
		logic         l8sel;
		logic         tb_latch;
		logic         tb_s1;
		logic         tb_s2;
		logic         tb_s3;
		logic         rst_s1;
		logic         rst_s2;
		logic [5:0]   rst_cnt;
		logic [1:0]   sync_cnt;
		logic [3:0]   rst_cause;
		logic         resume_pulse;
		logic         isr_pulse;
		logic         wdt_pulse;
		logic [7:0]   rdata;
		logic [7:0]   prescaler;
	} pmc_state_type;
endpackage : pmc_pkg
